// ### hw/sync_framer.sv
// Output framer for four data lanes plus a synchronisation lane.
// Assumes: register port and line requests on core_clk; pixel words and all lane
// outputs on link_clk; an external serializer shifts each parallel word out.
`timescale 1ns/100ps
`include "sync_framer_map.svh"

module sync_framer (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [8:0] reg_addr,
   input wire logic [9:0] reg_wdata,
   output logic [9:0] reg_rdata,
   input wire logic narrow_mode,
   input wire logic crc_seed_ones,
   input wire logic line_req,
   input wire logic line_black,
   input wire logic [7:0] win_active,
   input wire logic [7:0] win_first,
   input wire logic [7:0] win_last,
   input wire logic [7:0] line_words_m1,
   output logic line_ready,
   output logic line_done,
   input wire logic [9:0] pix_lane0,
   input wire logic [9:0] pix_lane1,
   input wire logic [9:0] pix_lane2,
   input wire logic [9:0] pix_lane3,
   output logic pix_take,
   output logic [9:0] lane0_word,
   output logic [9:0] lane1_word,
   output logic [9:0] lane2_word,
   output logic [9:0] lane3_word,
   output logic [9:0] sync_word,
   output logic fwd_clk
);

   // One check-code step over a word, MSB first; narrow runs the 8-bit code over bits 9:2
   function automatic logic [9:0] crc_step(input logic [9:0] crc, input logic [9:0] d, input logic narrow);
      logic [9:0] c;
      logic fb;
      c = crc;
      for (int i = 9; i >= 0; i--) begin
         if (!narrow || i >= 2) begin
            fb = (narrow ? c[7] : c[9]) ^ d[i];
            c = {c[8:0], 1'b0} ^ (fb ? (narrow ? {2'b00, `CRC8_POLY} : `CRC10_POLY) : 10'h000);
         end
      end
      return narrow ? {2'b00, c[7:0]} : c;
   endfunction

   // Shapes a programmed ten-bit code for the selected word width
   function automatic logic [9:0] fit_word(input logic [9:0] w, input logic narrow);
      return narrow ? {2'b00, w[9:2]} : w;
   endfunction

   // Builds a synchronisation code from type and marker
   function automatic logic [9:0] sync_code(input logic [2:0] kind, input logic [6:0] mark,
                                            input logic narrow);
      return narrow ? {2'b00, kind, mark[6:2]} : {kind, mark};
   endfunction

   // Highest active window index; lower windows are suppressed
   function automatic logic [2:0] top_window(input logic [7:0] act);
      logic [2:0] id;
      id = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (act[i]) begin
            id = 3'(i);
         end
      end
      return id;
   endfunction

   // Core-side register file
   logic [9:0] train_data_q;     // Data-lane training pattern
   logic [6:0] marker_q;         // Sync marker
   logic [9:0] black_class_q;    // Black classification code
   logic [9:0] image_class_q;    // Image classification code
   logic [9:0] check_class_q;    // Check-code indication
   logic [9:0] train_class_q;    // Training classification code
   logic [9:0] reg_rdata_q;      // Read data
   logic line_ready_q;           // No line pending
   logic line_done_q;            // One-cycle done pulse

   // Holding register: stable while a line is in flight, read by the link side
   logic [91:0] hold_q;
   logic req_tgl_q;
   logic ack_s1_q;
   logic ack_s2_q;
   logic ack_s3_q;

   // Link-side state
   logic lrst_meta_q;
   logic lrst_q;
   logic req_s1_q;
   logic req_s2_q;
   logic req_s3_q;
   logic ack_tgl_q;
   sync_framer_pkg::link_state_t state_q;
   sync_framer_pkg::link_state_t state_d;
   logic [91:0] desc_q;          // Line descriptor in use
   logic [7:0] cnt_q;            // Pixel words left minus one
   logic [9:0] crc_q [4];        // Per-lane check code
   logic [9:0] lane_q [4];       // Registered lane words
   logic [9:0] sync_q;
   logic pix_take_q;
   logic fwd_clk_q;

   // Descriptor field views on the link side
   logic l_narrow;
   logic l_seed1;
   logic l_black;
   logic [7:0] l_act;
   logic [7:0] l_first;
   logic [7:0] l_last;
   logic [7:0] l_words;
   logic [6:0] l_marker;
   logic [9:0] l_black_cls;
   logic [9:0] l_image_cls;
   logic [9:0] l_check_cls;
   logic [9:0] l_train_cls;
   logic [9:0] l_train_data;
   logic [2:0] l_win;
   logic [9:0] pix_in [4];
   logic req_evt;

   assign {l_narrow, l_seed1, l_black, l_act, l_first, l_last, l_words, l_marker,
           l_black_cls, l_image_cls, l_check_cls, l_train_cls, l_train_data} = desc_q;
   assign l_win = top_window(l_act);
   assign pix_in[0] = pix_lane0;
   assign pix_in[1] = pix_lane1;
   assign pix_in[2] = pix_lane2;
   assign pix_in[3] = pix_lane3;
   assign req_evt = req_s2_q ^ req_s3_q;

   // Register writes; the training class shares the hold with the data pattern
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         train_data_q <= `RST_TRAIN_DATA;
         marker_q <= `RST_SYNC_MARKER;
         black_class_q <= `RST_BLACK_CLASS;
         image_class_q <= `RST_IMAGE_CLASS;
         check_class_q <= `RST_CHECK_CLASS;
         train_class_q <= `RST_TRAIN_CLASS;
      end else if (reg_write) begin
         case (reg_addr)
            `ADDR_TRAIN_DATA: train_data_q <= reg_wdata;
            `ADDR_SYNC_MARKER: marker_q <= reg_wdata[6:0];
            `ADDR_BLACK_CLASS: black_class_q <= reg_wdata;
            `ADDR_IMAGE_CLASS: image_class_q <= reg_wdata;
            `ADDR_CHECK_CLASS: check_class_q <= reg_wdata;
            `ADDR_TRAIN_CLASS: train_class_q <= reg_wdata;
            default: ; // Unmapped writes are dropped
         endcase
      end
   end

   // Register reads answer one cycle later; unmapped reads give zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata_q <= 10'h000;
      end else if (reg_read) begin
         case (reg_addr)
            `ADDR_TRAIN_DATA: reg_rdata_q <= train_data_q;
            `ADDR_SYNC_MARKER: reg_rdata_q <= {3'b000, marker_q};
            `ADDR_BLACK_CLASS: reg_rdata_q <= black_class_q;
            `ADDR_IMAGE_CLASS: reg_rdata_q <= image_class_q;
            `ADDR_CHECK_CLASS: reg_rdata_q <= check_class_q;
            `ADDR_TRAIN_CLASS: reg_rdata_q <= train_class_q;
            `ADDR_FRAMER_STATUS: reg_rdata_q <= {9'h000, ~line_ready_q};
            default: reg_rdata_q <= 10'h000;
         endcase
      end
   end

   // Acknowledge toggle back from the link side
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         ack_s3_q <= 1'b0;
      end else begin
         ack_s1_q <= ack_tgl_q;
         ack_s2_q <= ack_s1_q;
         ack_s3_q <= ack_s2_q;
      end
   end

   // Line hand-off: one line in flight, so the hold stays still while the link reads it
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hold_q <= '0;
         req_tgl_q <= 1'b0;
         line_ready_q <= 1'b1;
         line_done_q <= 1'b0;
      end else begin
         line_done_q <= ack_s2_q ^ ack_s3_q;
         if (ack_s2_q ^ ack_s3_q) begin
            line_ready_q <= 1'b1;
         end else if (line_req && line_ready_q) begin
            // Config is snapshotted per line so a mid-line write cannot tear a word
            hold_q <= {narrow_mode, crc_seed_ones, line_black, win_active, win_first, win_last,
                       line_words_m1, marker_q, black_class_q, image_class_q, check_class_q,
                       train_class_q, train_data_q};
            req_tgl_q <= ~req_tgl_q;
            line_ready_q <= 1'b0;
         end
      end
   end

   // Link reset: asserts at once, releases on the link clock
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         lrst_meta_q <= 1'b1;
         lrst_q <= 1'b1;
      end else begin
         lrst_meta_q <= 1'b0;
         lrst_q <= lrst_meta_q;
      end
   end

   // Request toggle into the link domain
   always_ff @(posedge link_clk or posedge lrst_q) begin
      if (lrst_q) begin
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         req_s3_q <= 1'b0;
      end else begin
         req_s1_q <= req_tgl_q;
         req_s2_q <= req_s1_q;
         req_s3_q <= req_s2_q;
      end
   end

   // Line sequence: begin/finish codes only on window lines; black lines carry only class and check words
   always_comb begin
      state_d = state_q;
      case (state_q)
         sync_framer_pkg::ST_IDLE: begin
            if (req_evt) begin // Black lines carry no frame codes; the sequencer sends them straight to data
               state_d = hold_q[`HOLD_BLACK] ? sync_framer_pkg::ST_DATA : sync_framer_pkg::ST_BEGIN;
            end
         end
         sync_framer_pkg::ST_BEGIN: state_d = sync_framer_pkg::ST_BEGIN_ID;
         sync_framer_pkg::ST_BEGIN_ID: state_d = sync_framer_pkg::ST_DATA;
         sync_framer_pkg::ST_DATA: begin
            if (cnt_q == 8'h00) begin
               state_d = sync_framer_pkg::ST_CHECK;
            end
         end
         sync_framer_pkg::ST_CHECK: begin
            state_d = l_black ? sync_framer_pkg::ST_IDLE : sync_framer_pkg::ST_FINISH;
         end
         sync_framer_pkg::ST_FINISH: state_d = sync_framer_pkg::ST_FINISH_ID;
         sync_framer_pkg::ST_FINISH_ID: state_d = sync_framer_pkg::ST_IDLE;
         default: state_d = sync_framer_pkg::ST_IDLE;
      endcase
   end

   // State, descriptor capture, word count and completion toggle
   always_ff @(posedge link_clk or posedge lrst_q) begin
      if (lrst_q) begin
         state_q <= sync_framer_pkg::ST_IDLE;
         desc_q <= {3'h0, 32'h00000000, `RST_SYNC_MARKER, `RST_BLACK_CLASS, `RST_IMAGE_CLASS,
                    `RST_CHECK_CLASS, `RST_TRAIN_CLASS, `RST_TRAIN_DATA};
         cnt_q <= 8'h00;
         ack_tgl_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_q == sync_framer_pkg::ST_IDLE && req_evt) begin
            desc_q <= hold_q;
            cnt_q <= hold_q[`HOLD_WORDS];
         end else if (state_q == sync_framer_pkg::ST_DATA) begin
            cnt_q <= cnt_q - 8'h01;
         end
         if (state_q != sync_framer_pkg::ST_IDLE && state_d == sync_framer_pkg::ST_IDLE) begin
            ack_tgl_q <= ~ack_tgl_q;
         end
      end
   end

   // Per-lane check code: seeded on line entry, advanced by pixel words only
   always_ff @(posedge link_clk or posedge lrst_q) begin
      if (lrst_q) begin
         for (int k = 0; k < 4; k++) begin
            crc_q[k] <= 10'h000;
         end
      end else begin
         for (int k = 0; k < 4; k++) begin
            if (state_q == sync_framer_pkg::ST_IDLE) begin
               // Seed held through idle, so training words never enter
               crc_q[k] <= hold_q[`HOLD_SEED] ? (hold_q[`HOLD_NARROW] ? {2'b00, `CRC8_ONES} : `CRC10_ONES) : 10'h000;
            end else if (state_q == sync_framer_pkg::ST_DATA) begin
               crc_q[k] <= crc_step(crc_q[k], pix_in[k], l_narrow);
            end
         end
      end
   end

   // Lane words: pixels, check codes or training pattern, all in one register stage
   always_ff @(posedge link_clk or posedge lrst_q) begin
      if (lrst_q) begin
         for (int k = 0; k < 4; k++) begin
            lane_q[k] <= `RST_TRAIN_DATA;
         end
         pix_take_q <= 1'b0;
      end else begin
         pix_take_q <= (state_d == sync_framer_pkg::ST_DATA);
         for (int k = 0; k < 4; k++) begin
            case (state_q)
               sync_framer_pkg::ST_DATA: lane_q[k] <= fit_word(pix_in[k], l_narrow);
               sync_framer_pkg::ST_CHECK: lane_q[k] <= crc_q[k];
               default: lane_q[k] <= fit_word(l_train_data, l_narrow);
            endcase
         end
      end
   end

   // Sync lane word for the same cycle as the lane words
   always_ff @(posedge link_clk or posedge lrst_q) begin
      if (lrst_q) begin
         sync_q <= `RST_TRAIN_CLASS;
      end else begin
         case (state_q)
            sync_framer_pkg::ST_BEGIN: begin // First window line opens the frame
               sync_q <= sync_code(l_first[l_win] ? `TYPE_FRAME_BEGIN : `TYPE_ROW_BEGIN,
                                   l_marker, l_narrow);
            end
            sync_framer_pkg::ST_FINISH: begin
               sync_q <= sync_code(l_last[l_win] ? `TYPE_FRAME_FINISH : `TYPE_ROW_FINISH,
                                   l_marker, l_narrow);
            end
            sync_framer_pkg::ST_BEGIN_ID, sync_framer_pkg::ST_FINISH_ID: begin
               sync_q <= l_narrow ? {5'h00, l_win, 2'b00} : {7'h00, l_win};
            end
            sync_framer_pkg::ST_DATA: begin // Line belongs to the highest active window only; sync shows class only
               sync_q <= fit_word(l_black ? l_black_cls : l_image_cls, l_narrow);
            end
            sync_framer_pkg::ST_CHECK: sync_q <= fit_word(l_check_cls, l_narrow);
            default: sync_q <= fit_word(l_train_cls, l_narrow);
         endcase
      end
   end

   // Forwarded clock: half link rate, edges on the same link edge as each word change for a DDR-style receiver
   always_ff @(posedge link_clk or posedge lrst_q) begin
      if (lrst_q) begin
         fwd_clk_q <= 1'b0;
      end else begin
         fwd_clk_q <= ~fwd_clk_q;
      end
   end

   // Pixel order within a line and line order are the readout source's; words pass in order
   assign reg_rdata = reg_rdata_q;
   assign line_ready = line_ready_q;
   assign line_done = line_done_q;
   assign pix_take = pix_take_q;
   assign lane0_word = lane_q[0];
   assign lane1_word = lane_q[1];
   assign lane2_word = lane_q[2];
   assign lane3_word = lane_q[3];
   assign sync_word = sync_q;
   assign fwd_clk = fwd_clk_q;

endmodule

// ### shared/sync_framer_map.svh
// Register offsets, reset values, code types and CRC constants of the framer.
// Assumes inclusion by bare name from the design file and the testbench.
`ifndef SYNC_FRAMER_MAP_SVH
`define SYNC_FRAMER_MAP_SVH

// Register indices on the internal register port
`define ADDR_TRAIN_DATA 9'h082
`define ADDR_SYNC_MARKER 9'h083
`define ADDR_BLACK_CLASS 9'h084
`define ADDR_IMAGE_CLASS 9'h085
`define ADDR_CHECK_CLASS 9'h086
`define ADDR_TRAIN_CLASS 9'h087
`define ADDR_FRAMER_STATUS 9'h088

// Reset values
`define RST_TRAIN_DATA 10'h3A6
`define RST_SYNC_MARKER 7'h2A
`define RST_BLACK_CLASS 10'h015
`define RST_IMAGE_CLASS 10'h035
`define RST_CHECK_CLASS 10'h059
`define RST_TRAIN_CLASS 10'h3A6

// Code type field of a synchronisation word
`define TYPE_FRAME_BEGIN 3'h5
`define TYPE_FRAME_FINISH 3'h6
`define TYPE_ROW_BEGIN 3'h1
`define TYPE_ROW_FINISH 3'h2

// Check-code feedback masks (terms below the top degree)
`define CRC10_POLY 10'h24F
`define CRC8_POLY 8'h4D
`define CRC10_ONES 10'h3FF
`define CRC8_ONES 8'h0FF

// Field positions in the line descriptor handed to the link side
`define HOLD_NARROW 91
`define HOLD_SEED 90
`define HOLD_BLACK 89
`define HOLD_WORDS 64:57

`endif

// ### shared/sync_framer_pkg.sv
// Types shared by the synchronisation-lane framer.
// Assumes the map header sits beside it on the include path.
package sync_framer_pkg;

   // Link-side line sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_BEGIN = 3'b001,
      ST_BEGIN_ID = 3'b010,
      ST_DATA = 3'b011,
      ST_CHECK = 3'b100,
      ST_FINISH = 3'b101,
      ST_FINISH_ID = 3'b110
   } link_state_t;

   // Lane word as sent each link cycle
   typedef logic [9:0] lane_word_t;

endpackage

// ### verif/line_receiver.sv
// Receiving deserializer model: keeps every non-idle word pair of a line.
// Assumes parallel words per link cycle; idle_code is the programmed training class.
`timescale 1ns/100ps
module line_receiver (
   input wire logic link_clk,
   input wire logic rst,
   input wire logic [9:0] sync_word,
   input wire logic [9:0] lane_word,
   input wire logic [9:0] idle_code
);
   logic [9:0] sync_q [$]; // Sync words of the current line
   logic [9:0] lane_q [$]; // Lane 0 words in the same cycles

   // Anything but the training class belongs to a line; rebuild it in order.
   // Idle before a line still shows the previous line's width, so both widths count as idle.
   always @(posedge link_clk) begin
      if (!rst && sync_word !== idle_code && sync_word !== {2'b00, idle_code[9:2]}) begin
         sync_q.push_back(sync_word);
         lane_q.push_back(lane_word);
      end
   end
endmodule

// ### verif/lvds_sync_channel_framer_tb.sv
// Self-checking bench for the framer: registers, image and black lines.
// Assumes the receiver model and the checker bound to the design.
`timescale 1ns/100ps
`include "sync_framer_map.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module lvds_sync_channel_framer_tb;
   logic core_clk = 1'b0, link_clk = 1'b0, rst = 1'b1;
   logic reg_write = 1'b0, reg_read = 1'b0, narrow_mode = 1'b0, crc_seed_ones = 1'b0, line_req = 1'b0;
   logic line_black = 1'b0, line_ready, line_done, pix_take, fwd_clk;
   logic [8:0] reg_addr = 9'h000;
   logic [7:0] win_active = 8'h01, win_first = 8'h00, win_last = 8'h00, line_words_m1 = 8'h00, pidx = 8'h00;
   logic [9:0] reg_wdata = 10'h000, reg_rdata, lw0, lw1, lw2, lw3, sync_word, rd;
   logic [9:0] pa [4][256]; // Pixel words per lane for the current line
   logic [9:0] mk = 10'h02A, bl = 10'h015, im = 10'h035, ck = 10'h059, tr = 10'h3A6, tp = 10'h3A6;
   logic [9:0] dflt [9] = '{10'h000, 10'h3A6, 10'h02A, 10'h015, 10'h035, 10'h059, 10'h3A6, 10'h000, 10'h000};
   logic [9:0] exp_s [$], exp_l [$]; // Expected sync and lane 0 words
   int bad_count = 0, tests_run = 0;

   // Core clock 100 ns; link clock 125 ns with an unrelated phase
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      #17;
      forever #62.5 link_clk = ~link_clk;
   end

   // Pixel source steps once per consumed word
   always @(posedge link_clk) begin
      if (pix_take) begin
         pidx <= pidx + 8'h01;
      end
   end

   sync_framer u_dut (.core_clk, .rst, .link_clk, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
      .narrow_mode, .crc_seed_ones, .line_req, .line_black, .win_active, .win_first, .win_last, .line_words_m1,
      .line_ready, .line_done, .pix_lane0(pa[0][pidx]), .pix_lane1(pa[1][pidx]), .pix_lane2(pa[2][pidx]),
      .pix_lane3(pa[3][pidx]), .pix_take, .lane0_word(lw0), .lane1_word(lw1), .lane2_word(lw2),
      .lane3_word(lw3), .sync_word, .fwd_clk);
   line_receiver u_rx (.link_clk, .rst, .sync_word, .lane_word(lw0), .idle_code(tr));

   // Word as sent in the chosen mode: narrow drops the two low bits
   function automatic logic [9:0] nw(input logic nar, input logic [9:0] v);
      return nar ? {2'b00, v[9:2]} : v;
   endfunction

   // Sync code word of one type with the programmed marker
   function automatic logic [9:0] code(input logic nar, input logic [2:0] t);
      return nar ? {2'b00, t, mk[6:2]} : {t, mk[6:0]};
   endfunction

   // Serial check code of lane 0, MSB first, over words 0..n
   function automatic logic [9:0] crc(input logic nar, input logic so, input logic [7:0] n);
      logic [9:0] c;
      logic fb;
      c = so ? `CRC10_ONES : 10'h000;
      for (int k = 0; k <= n; k++) begin
         for (int b = 9; b >= (nar ? 2 : 0); b--) begin
            fb = (nar ? c[7] : c[9]) ^ pa[0][k][b];
            c = {c[8:0], 1'b0} ^ (fb ? (nar ? 10'h04D : `CRC10_POLY) : 10'h000);
         end
      end
      return nar ? {2'b00, c[7:0]} : c;
   endfunction

   task automatic reg_wr(input logic [8:0] a, input logic [9:0] d);
      @(negedge core_clk);
      reg_write = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_write = 1'b0;
   endtask

   task automatic reg_rd(input logic [8:0] a, output logic [9:0] d);
      @(negedge core_clk);
      reg_read = 1'b1;
      reg_addr = a;
      @(negedge core_clk);
      reg_read = 1'b0;
      d = reg_rdata;
   endtask

   task test_done;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // One line through the handshake, then compare what the receiver rebuilt
   task automatic run_line(input logic nar, so, blk, input logic [7:0] act, fst, lst, n);
      int id;
      int w;
      id = 0;
      for (int b = 0; b < 8; b++) begin
         if (act[b]) id = b;
      end
      foreach (pa[l, k]) pa[l][k] = 10'($urandom);
      pidx = 8'h00;
      exp_s = {};
      exp_l = {};
      u_rx.sync_q = {};
      u_rx.lane_q = {};
      if (!blk) begin
         exp_s.push_back(code(nar, fst[id] ? `TYPE_FRAME_BEGIN : `TYPE_ROW_BEGIN));
         exp_s.push_back(nar ? 10'(id << 2) : 10'(id));
         exp_l.push_back(nw(nar, tp));
         exp_l.push_back(nw(nar, tp));
      end
      for (int k = 0; k <= n; k++) begin
         exp_s.push_back(nw(nar, blk ? bl : im));
         exp_l.push_back(nw(nar, pa[0][k]));
      end
      exp_s.push_back(nw(nar, ck));
      exp_l.push_back(crc(nar, so, n));
      if (!blk) begin
         exp_s.push_back(code(nar, lst[id] ? `TYPE_FRAME_FINISH : `TYPE_ROW_FINISH));
         exp_s.push_back(nar ? 10'(id << 2) : 10'(id));
         exp_l.push_back(nw(nar, tp));
         exp_l.push_back(nw(nar, tp));
      end
      @(negedge core_clk);
      narrow_mode = nar; // Both clocks keep their rate in narrow mode
      crc_seed_ones = so;
      line_black = blk;
      win_active = act;
      win_first = fst;
      win_last = lst;
      line_words_m1 = n;
      line_req = 1'b1;
      @(negedge core_clk);
      line_req = 1'b0;
      w = 0;
      while (line_done !== 1'b1 && w < 1000) begin
         @(negedge core_clk);
         w++;
      end
      if (w == 1000) begin
         bad_count++;
         test_done;
      end
      `CHK("line length", exp_s.size(), u_rx.sync_q.size())
      for (int i = 0; i < exp_s.size() && i < u_rx.sync_q.size(); i++) begin
         `CHK("sync word", exp_s[i], u_rx.sync_q[i])
         `CHK("lane word", exp_l[i], u_rx.lane_q[i])
      end
      `CHK("idle lane", nw(nar, tp), lw0)
      `CHK("idle lanes", {3{nw(nar, tp)}}, {lw1, lw2, lw3})
   endtask

   initial begin
      void'($urandom(32'h09af3ceb));
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      // Unmapped write must leave every register at its reset value
      reg_wr(9'h089, 10'h155);
      for (int a = 'h81; a <= 'h89; a++) begin
         reg_rd(9'(a), rd);
         `CHK("register", dflt[a - 'h81], rd)
      end
      $display("test registers done");
      for (int i = 0; i < 12; i++) begin
         // Halfway, reprogram codes; small values keep every code clear of both idle widths
         if (i == 6) begin
            mk = 10'($urandom_range(0, 63));
            bl = 10'($urandom_range(0, 63));
            im = bl ^ 10'h083;
            ck = bl ^ 10'h03C;
            tp = 10'($urandom);
            reg_wr(9'h082, tp);
            reg_wr(9'h083, mk);
            reg_wr(9'h084, bl);
            reg_wr(9'h085, im);
            reg_wr(9'h086, ck);
            reg_rd(9'h083, rd);
            `CHK("marker", mk, rd)
         end
         run_line(i[0], i[1], i % 4 == 3, i == 0 ? 8'h81 : 8'($urandom_range(1, 255)), 8'($urandom),
            8'($urandom), i == 0 ? 8'h00 : 8'($urandom_range(1, 7)));
         $display("test line %0d done", i);
      end
      test_done;
   end
endmodule

// ### verif/sync_framer_props.sv
// Concurrent checks on the framer's ports, core and link domains.
// Assumes binding to sync_framer; rst resets both domains.
`timescale 1ns/100ps
module sync_framer_props (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic reg_read,
   input wire logic [8:0] reg_addr,
   input wire logic [9:0] reg_rdata,
   input wire logic line_req,
   input wire logic line_ready,
   input wire logic line_done,
   input wire logic [9:0] pix_lane0,
   input wire logic [9:0] pix_lane3,
   input wire logic pix_take,
   input wire logic [9:0] lane0_word,
   input wire logic [9:0] lane3_word,
   input wire logic fwd_clk
);
   logic [2:0] lrun_q; // Link cycles since reset, saturating
   logic [9:0] p0_q; // Pixel word offered on lane 0 last cycle
   logic [9:0] p3_q; // Pixel word offered on lane 3 last cycle

   // Link side holds its outputs for a few edges after reset, so wait
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         lrun_q <= 3'h0;
      end else if (lrun_q != 3'h7) begin
         lrun_q <= lrun_q + 3'h1;
      end
   end

   // Keep the offered pixels to compare with next cycle's lane words
   always_ff @(posedge link_clk) begin
      p0_q <= pix_lane0;
      p3_q <= pix_lane3;
   end

   chk_fwd_toggles: assert property (@(posedge link_clk) disable iff (rst)
      lrun_q == 3'h7 |-> fwd_clk != $past(fwd_clk)) else $error("forwarded clock did not toggle");
   chk_lane0_pixel: assert property (@(posedge link_clk) disable iff (rst)
      pix_take |=> (lane0_word == p0_q || lane0_word == {2'b00, p0_q[9:2]})) else $error("lane 0 word not pixel");
   chk_lane3_pixel: assert property (@(posedge link_clk) disable iff (rst)
      pix_take |=> (lane3_word == p3_q || lane3_word == {2'b00, p3_q[9:2]})) else $error("lane 3 word not pixel");
   chk_done_ready: assert property (@(posedge core_clk) disable iff (rst)
      line_done |-> line_ready) else $error("line done without ready");
   chk_done_pulse: assert property (@(posedge core_clk) disable iff (rst)
      line_done |=> !line_done) else $error("line done longer than one cycle");
   chk_req_taken: assert property (@(posedge core_clk) disable iff (rst)
      line_req && line_ready |=> !line_ready) else $error("line request not taken");
   chk_ready_rise: assert property (@(posedge core_clk) disable iff (rst)
      $rose(line_ready) |-> line_done) else $error("ready returned without done");
   chk_done_bound: assert property (@(posedge core_clk) disable iff (rst)
      $fell(line_ready) |-> ##[1:1000] line_done) else $error("line never finished");
   chk_rdata_hold: assert property (@(posedge core_clk) disable iff (rst)
      !reg_read |=> $stable(reg_rdata)) else $error("read data changed without read");
   chk_unmapped_zero: assert property (@(posedge core_clk) disable iff (rst)
      reg_read && (reg_addr < 9'h082 || reg_addr > 9'h088) |=> reg_rdata == 10'h000) else $error("unmapped read not 0");

   cov_line: cover property (@(posedge core_clk) disable iff (rst) line_done);
   cov_pixel: cover property (@(posedge link_clk) disable iff (rst) pix_take);
   cov_unmapped: cover property (@(posedge core_clk) disable iff (rst) reg_read && reg_addr == 9'h081);
endmodule

bind sync_framer sync_framer_props u_props (.core_clk(core_clk), .rst(rst), .link_clk(link_clk),
   .reg_read(reg_read), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .line_req(line_req),
   .line_ready(line_ready), .line_done(line_done), .pix_lane0(pix_lane0), .pix_lane3(pix_lane3),
   .pix_take(pix_take), .lane0_word(lane0_word), .lane3_word(lane3_word), .fwd_clk(fwd_clk));
